/* hw/dlr_pkg.sv */
// Purpose: constants and types for the door learn-run and manual drive block
// Assumes: position counted in millimetres by the position input, 100 MHz clock
// Notes: no software registers; every control and status bit is a plain port
package dlr_pkg;
    localparam int POS_W         = 16;
    localparam int VAL_W         = 16;
    localparam int SEL_W         = 6;
    localparam logic [POS_W-1:0] PRE_OPEN_MM  = 16'h0064; // 10 cm
    localparam logic [POS_W-1:0] FRICT_MM     = 16'h00fa; // 25 cm
    localparam logic [POS_W-1:0] MASS_RAMP_MM = 16'h0096; // 15 cm
    localparam logic [1:0] PRE_CLOSES    = 2'h2;
    localparam int HOLD_NS        = 500000000;
    localparam int CLK_NS         = 10;
    localparam int HOLD_CYC       = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] SPD_STOP = 2'h0;
    localparam logic [1:0] SPD_SLOW = 2'h1;
    localparam logic [1:0] SPD_RED  = 2'h2;
    localparam logic [1:0] SPD_RAMP = 2'h3;
    localparam logic [SEL_W-1:0] SEL_LAST = 6'h3f;

    typedef enum logic [3:0] {
        DLR_IDLE    = 4'b0000,
        DLR_ARM     = 4'b0001,
        DLR_PRE_OP  = 4'b0010,
        DLR_PRE_CL  = 4'b0011,
        DLR_FR_OP   = 4'b0100,
        DLR_FR_CL   = 4'b0101,
        DLR_FULL_OP = 4'b0110,
        DLR_FULL_CL = 4'b0111,
        DLR_COMMIT  = 4'b1000
    } dlr_state_t;
endpackage

/* hw/dlr_keypad.sv */
// Purpose: keypad parameter selection and edit
// Assumes: key inputs are one-cycle pulses, already debounced
// Notes: edited value is held until enter commits it
`timescale 1ns/1ps
`default_nettype none
module dlr_keypad
    import dlr_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 rstn,
    input  wire logic                 ce,
    input  wire logic                 key_up,
    input  wire logic                 key_down,
    input  wire logic                 key_enter,
    input  wire logic [VAL_W-1:0]     cur_value,
    output logic      [SEL_W-1:0]     sel_q,
    output logic                      editing_q,
    output logic      [VAL_W-1:0]     edit_val_q,
    output logic                      commit_q
);
    wire logic sel_up   = key_up && !editing_q && sel_q != SEL_LAST;
    wire logic sel_down = key_down && !editing_q && sel_q != '0;
    wire logic go_edit  = key_enter && !editing_q;
    wire logic go_done  = key_enter && editing_q;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            sel_q      <= '0;
            editing_q  <= 1'b0;
            edit_val_q <= '0;
            commit_q   <= 1'b0;
        end
        else if (ce)
        begin
            commit_q <= go_done;
            if (sel_up)
                sel_q <= sel_q + 1'b1;
            else if (sel_down)
                sel_q <= sel_q - 1'b1;
            if (go_edit)
            begin
                editing_q  <= 1'b1;
                edit_val_q <= cur_value;
            end
            else if (go_done)
                editing_q <= 1'b0;
            else if (editing_q && key_up && edit_val_q != '1)
                edit_val_q <= edit_val_q + 1'b1;
            else if (editing_q && key_down && edit_val_q != '0)
                edit_val_q <= edit_val_q - 1'b1;
        end
    end
endmodule
`default_nettype wire

/* hw/dlr_top.sv */
// Purpose: learn-run sequencer, manual drive arbitration, parameter apply
// Assumes: pos_mm counts millimetres from closed; closed_end/open_end from encoder logic
// Notes: mass and friction come from the motor controller as measured values
`timescale 1ns/1ps
`default_nettype none
module dlr_top
    import dlr_pkg::*;
#(
    parameter int HOLD_CYCLES = HOLD_CYC
)
(
    input  wire logic                    clock,
    input  wire logic                    rstn,
    input  wire logic                    ce,
    input  wire logic                    learn_push_button,
    input  wire logic                    manual_open_button,
    input  wire logic                    manual_close_button,
    input  wire logic                    ext_open_cmd,
    input  wire logic                    ext_close_cmd,
    input  wire logic                    stop_disable_dcu,
    input  wire logic                    service_menu_lock,
    input  wire logic                    normal_mode,
    input  wire logic                    initial_mode_apply,
    input  wire logic [dlr_pkg::POS_W-1:0] pos_mm,
    input  wire logic                    closed_end,
    input  wire logic                    open_end,
    input  wire logic [dlr_pkg::VAL_W-1:0] meas_mass,
    input  wire logic [dlr_pkg::VAL_W-1:0] meas_friction,
    input  wire logic [dlr_pkg::VAL_W-1:0] meas_energy,
    input  wire logic [dlr_pkg::VAL_W-1:0] meas_speed,
    input  wire logic                    key_up,
    input  wire logic                    key_down,
    input  wire logic                    key_enter,
    input  wire logic [dlr_pkg::VAL_W-1:0] param_rd_value,
    output logic                         motor_open_q,
    output logic                         motor_close_q,
    output logic [1:0]                   motor_speed_q,
    output logic                         learn_active_q,
    output logic                         store_q,
    output logic [dlr_pkg::POS_W-1:0]    door_width_q,
    output logic [dlr_pkg::VAL_W-1:0]    mass_q,
    output logic [dlr_pkg::VAL_W-1:0]    energy_lim_q,
    output logic [dlr_pkg::VAL_W-1:0]    speed_lim_q,
    output logic [dlr_pkg::VAL_W-1:0]    friction_q,
    output logic [dlr_pkg::SEL_W-1:0]    param_sel_q,
    output logic                         param_flash_q,
    output logic [dlr_pkg::VAL_W-1:0]    param_edit_q,
    output logic                         param_wr_q,
    output logic [dlr_pkg::SEL_W-1:0]    param_wr_sel_q,
    output logic [dlr_pkg::VAL_W-1:0]    param_wr_val_q
);
    import dlr_pkg::*;

    dlr_state_t       st_q, st_d;
    logic [31:0]      hold_q;
    logic [1:0]       ncl_q;
    logic             ramp_done_q;
    logic             pend_q;
    logic             kp_commit;
    logic [SEL_W-1:0] kp_sel;
    logic             kp_edit;
    logic [VAL_W-1:0] kp_val;

    dlr_keypad u_keypad (
        .clock      (clock),
        .rstn       (rstn),
        .ce         (ce),
        .key_up     (key_up),
        .key_down   (key_down),
        .key_enter  (key_enter),
        .cur_value  (param_rd_value),
        .sel_q      (kp_sel),
        .editing_q  (kp_edit),
        .edit_val_q (kp_val),
        .commit_q   (kp_commit)
    );

    // manual drive: external inputs masked by service menus, buttons by stop-disable
    wire logic ext_ok   = !service_menu_lock;
    wire logic btn_ok   = !stop_disable_dcu;
    wire logic req_open = (manual_open_button && btn_ok) || (ext_open_cmd && ext_ok);
    wire logic req_cls  = (manual_close_button && btn_ok) || (ext_close_cmd && ext_ok);
    wire logic man_open = req_open && !open_end;
    wire logic man_cls  = req_cls && !req_open && !closed_end;
    wire logic learning = st_q != DLR_IDLE && st_q != DLR_ARM;
    wire logic hold_done = hold_q >= 32'(HOLD_CYCLES - 1);
    wire logic in_ramp  = st_q == DLR_FULL_OP && !ramp_done_q && pos_mm >= MASS_RAMP_MM;
    wire logic standstill = !motor_open_q && !motor_close_q && !learning;
    wire logic apply_ok = standstill && (normal_mode || initial_mode_apply);

    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            DLR_IDLE:
                if (learn_push_button && closed_end && normal_mode)
                    st_d = DLR_ARM;
            DLR_ARM:
                if (!learn_push_button || !closed_end)
                    st_d = DLR_IDLE;
                else if (hold_done)
                    st_d = DLR_PRE_OP;
            DLR_PRE_OP:
                if (pos_mm >= PRE_OPEN_MM)
                    st_d = DLR_PRE_CL;
            DLR_PRE_CL:
                if (closed_end)
                    st_d = (ncl_q + 2'h1 >= PRE_CLOSES) ? DLR_FR_OP : DLR_PRE_OP;
            DLR_FR_OP:
                if (pos_mm >= FRICT_MM)
                    st_d = DLR_FR_CL;
            DLR_FR_CL:
                if (closed_end)
                    st_d = DLR_FULL_OP;
            DLR_FULL_OP:
                if (open_end)
                    st_d = DLR_FULL_CL;
            DLR_FULL_CL:
                if (closed_end)
                    st_d = DLR_COMMIT;
            DLR_COMMIT:
                st_d = DLR_IDLE;
            default:
                st_d = DLR_IDLE;
        endcase
    end

    wire logic lopen = st_q == DLR_PRE_OP || st_q == DLR_FR_OP || st_q == DLR_FULL_OP;
    wire logic lcls  = st_q == DLR_PRE_CL || st_q == DLR_FR_CL || st_q == DLR_FULL_CL;
    wire logic full  = st_q == DLR_FULL_OP || st_q == DLR_FULL_CL;
    // learn owns the motor; manual requests are ignored, not held, until it ends
    wire logic nx_open = learning ? (lopen && st_d == st_q) : man_open;
    wire logic nx_cls  = learning ? (lcls && st_d == st_q) : man_cls;
    wire logic [1:0] nx_spd = in_ramp ? SPD_RAMP : full ? SPD_RED :
                              learning ? SPD_SLOW : (nx_open || nx_cls) ? SPD_SLOW : SPD_STOP;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q        <= DLR_IDLE;
            hold_q      <= '0;
            ncl_q       <= '0;
            ramp_done_q <= 1'b0;
            pend_q      <= 1'b0;
        end
        else if (ce)
        begin
            st_q   <= st_d;
            hold_q <= (st_q == DLR_ARM) ? hold_q + 32'h0000_0001 : '0;
            if (st_q == DLR_IDLE)
                ncl_q <= '0;
            else if (st_q == DLR_PRE_CL && closed_end)
                ncl_q <= ncl_q + 2'h1;
            if (st_q == DLR_IDLE)
                ramp_done_q <= 1'b0;
            else if (in_ramp && pos_mm >= MASS_RAMP_MM + MASS_RAMP_MM)
                ramp_done_q <= 1'b1;
            // a commit made while moving, or outside normal and initial-apply mode, is kept until apply_ok;
            // one applied at once is not kept, or it would write twice
            if (kp_commit && !apply_ok)
                pend_q <= 1'b1;
            else if (apply_ok)
                pend_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            motor_open_q   <= 1'b0;
            motor_close_q  <= 1'b0;
            motor_speed_q  <= SPD_STOP;
            learn_active_q <= 1'b0;
            store_q        <= 1'b0;
            door_width_q   <= '0;
            mass_q         <= '0;
            energy_lim_q   <= '0;
            speed_lim_q    <= '0;
            friction_q     <= '0;
            param_sel_q    <= '0;
            param_flash_q  <= 1'b0;
            param_edit_q   <= '0;
            param_wr_q     <= 1'b0;
            param_wr_sel_q <= '0;
            param_wr_val_q <= '0;
        end
        else if (ce)
        begin
            motor_open_q   <= nx_open;
            motor_close_q  <= nx_cls;
            motor_speed_q  <= nx_spd;
            learn_active_q <= learning;
            store_q        <= st_q == DLR_COMMIT;
            if (st_q == DLR_FULL_OP && open_end)
                door_width_q <= pos_mm;
            if (in_ramp)
                mass_q <= meas_mass;
            if (st_q == DLR_FR_CL)
                friction_q <= meas_friction;
            if (st_q == DLR_COMMIT)
            begin
                energy_lim_q <= meas_energy;
                speed_lim_q  <= meas_speed;
            end
            param_sel_q   <= kp_sel;
            param_flash_q <= kp_edit;
            param_edit_q  <= kp_val;
            param_wr_q    <= (pend_q || kp_commit) && apply_ok;
            if (kp_commit)
            begin
                param_wr_sel_q <= kp_sel;
                param_wr_val_q <= kp_val;
            end
        end
    end
endmodule
`default_nettype wire

/* tb/dlr_door_model.sv */
// Purpose: geared door motor with position encoder, seen from the drive block
// Assumes: door moves 1 mm per clock while driven, starts closed
// Notes: open wins if both drives are high, except at the open end where close moves it; the block should never do that
`timescale 1ns/1ps
`default_nettype none
module dlr_door_model
    import dlr_pkg::*;
#(
    parameter int               WIDTH_MM = 600,
    parameter logic [VAL_W-1:0] MASS     = 16'h0000,
    parameter logic [VAL_W-1:0] FRIC     = 16'h0000,
    parameter logic [VAL_W-1:0] ENRG     = 16'h0000,
    parameter logic [VAL_W-1:0] SPD      = 16'h0000
)
(
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic             drive_open,
    input  wire logic             drive_close,
    output logic      [POS_W-1:0] pos_mm,
    output logic                  closed_end,
    output logic                  open_end,
    output logic      [VAL_W-1:0] meas_mass,
    output logic      [VAL_W-1:0] meas_friction,
    output logic      [VAL_W-1:0] meas_energy,
    output logic      [VAL_W-1:0] meas_speed
);
    assign closed_end    = (pos_mm == '0);
    assign open_end      = (pos_mm == POS_W'(WIDTH_MM));
    assign meas_mass     = MASS;
    assign meas_friction = FRIC;
    assign meas_energy   = ENRG;
    assign meas_speed    = SPD;
    // end stops are mechanical: driving into them does nothing
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            pos_mm <= '0;
        else if (drive_open && !open_end)
            pos_mm <= pos_mm + 16'h0001;
        else if (drive_close && !closed_end)
            pos_mm <= pos_mm - 16'h0001;
    end
endmodule
`default_nettype wire

/* tb/dlr_checker.sv */
// Purpose: port checks for dlr_top
// Assumes: single clock domain, rstn async active low
// Notes: motor may run while learning, so manual checks allow learn_active_q
`timescale 1ns/1ps
`default_nettype none
module dlr_checker
    import dlr_pkg::*;
(
    input wire logic             clock,
    input wire logic             rstn,
    input wire logic             ce,
    input wire logic             learn_push_button,
    input wire logic             manual_open_button,
    input wire logic             manual_close_button,
    input wire logic             ext_open_cmd,
    input wire logic             ext_close_cmd,
    input wire logic             stop_disable_dcu,
    input wire logic             service_menu_lock,
    input wire logic             normal_mode,
    input wire logic [POS_W-1:0] pos_mm,
    input wire logic             closed_end,
    input wire logic             open_end,
    input wire logic             key_enter,
    input wire logic             motor_open_q,
    input wire logic             motor_close_q,
    input wire logic [1:0]       motor_speed_q,
    input wire logic             learn_active_q,
    input wire logic             store_q,
    input wire logic             param_flash_q,
    input wire logic             param_wr_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    wire quiet = ce && !learn_push_button;
    wire halt  = learn_active_q || (!motor_open_q && !motor_close_q);
    wire still = !motor_open_q && !motor_close_q;
    a_open_wins: assert property (quiet && !stop_disable_dcu && manual_open_button
        && manual_close_button && !open_end |=> learn_active_q || (motor_open_q && !motor_close_q))
        else $error("open did not win over close");
    a_stop_masks: assert property (quiet && stop_disable_dcu && !ext_open_cmd
        && !ext_close_cmd |=> halt) else $error("service button moved door during stop");
    a_ext_locked: assert property (quiet && service_menu_lock && !manual_open_button
        && !manual_close_button |=> halt) else $error("external command acted while locked");
    a_hold_run: assert property (quiet && !manual_open_button && !manual_close_button
        && !ext_open_cmd && !ext_close_cmd |=> halt) else $error("door moved without command");
    a_learn_start: assert property ($rose(learn_active_q) |-> motor_open_q
        && motor_speed_q == SPD_SLOW) else $error("learn did not start slow opening");
    a_mass_ramp: assert property (learn_active_q && motor_speed_q == SPD_RAMP
        |-> motor_open_q && pos_mm >= MASS_RAMP_MM) else $error("mass ramp out of place");
    a_store_closed: assert property (store_q |-> closed_end && still)
        else $error("learned values stored away from closed end");
    a_edit_enter: assert property (ce && key_enter && !param_flash_q |-> ##2 param_flash_q)
        else $error("enter did not start edit");
    a_edit_commit: assert property (ce && key_enter && param_flash_q && normal_mode
        && still && !learn_active_q |-> ##[1:3] param_wr_q) else $error("second enter did not write");
    c_learn: cover property ($rose(learn_active_q));
    c_store: cover property (store_q);
    c_write: cover property (param_wr_q);
    c_both:  cover property (manual_open_button && manual_close_button);
endmodule
bind dlr_top dlr_checker u_chk (.clock(clock), .rstn(rstn), .ce(ce),
    .learn_push_button(learn_push_button), .manual_open_button(manual_open_button),
    .manual_close_button(manual_close_button), .ext_open_cmd(ext_open_cmd),
    .ext_close_cmd(ext_close_cmd), .stop_disable_dcu(stop_disable_dcu),
    .service_menu_lock(service_menu_lock), .normal_mode(normal_mode), .pos_mm(pos_mm),
    .closed_end(closed_end), .open_end(open_end), .key_enter(key_enter),
    .motor_open_q(motor_open_q), .motor_close_q(motor_close_q), .motor_speed_q(motor_speed_q),
    .learn_active_q(learn_active_q), .store_q(store_q), .param_flash_q(param_flash_q),
    .param_wr_q(param_wr_q));
`default_nettype wire

/* tb/tb.sv */
// Purpose: self-checking bench for dlr_top with a door model
// Assumes: door 600 mm wide, 1 mm per cycle; hold count cut to 4
// Notes: turn points may overshoot by a few mm, since motor outputs are registered
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dlr_pkg::*;
    localparam logic [VAL_W-1:0] MASS = 16'h0123, FRIC = 16'h0045, ENRG = 16'h0678, SPD = 16'h009a;
    logic clock = 1'b0, rstn = 1'b0, lb = 1'b0, mo = 1'b0, mc = 1'b0, eo = 1'b0, ec = 1'b0;
    logic stp = 1'b0, lck = 1'b0, ku = 1'b0, kd = 1'b0, ke = 1'b0, po = 1'b0;
    logic ce = 1'b1, nm = 1'b1, ima = 1'b0;
    wire m_op, m_cl, act, st, fl, pwr, clo, ope;
    wire [POS_W-1:0] pos, wid;
    wire [VAL_W-1:0] ms, fr, en, sp, mq, eq, sq, fq, pev, wv;
    wire [SEL_W-1:0] sel, wsel;
    wire [1:0] spd;
    int error_cnt = 0, cmp_count = 0;
    logic [POS_W-1:0] peaks[$];
    always #5 clock = ~clock;
    dlr_top #(.HOLD_CYCLES(4)) DUT (.clock(clock), .rstn(rstn), .ce(ce),
        .learn_push_button(lb), .manual_open_button(mo), .manual_close_button(mc),
        .ext_open_cmd(eo), .ext_close_cmd(ec), .stop_disable_dcu(stp), .service_menu_lock(lck),
        .normal_mode(nm), .initial_mode_apply(ima), .pos_mm(pos), .closed_end(clo),
        .open_end(ope), .meas_mass(ms), .meas_friction(fr), .meas_energy(en), .meas_speed(sp),
        .key_up(ku), .key_down(kd), .key_enter(ke), .param_rd_value(16'h0010),
        .motor_open_q(m_op), .motor_close_q(m_cl), .motor_speed_q(spd), .learn_active_q(act),
        .store_q(st), .door_width_q(wid), .mass_q(mq), .energy_lim_q(eq), .speed_lim_q(sq),
        .friction_q(fq), .param_sel_q(sel), .param_flash_q(fl), .param_edit_q(pev),
        .param_wr_q(pwr), .param_wr_sel_q(wsel), .param_wr_val_q(wv));
    dlr_door_model #(.WIDTH_MM(600), .MASS(MASS), .FRIC(FRIC), .ENRG(ENRG), .SPD(SPD)) u_door (
        .clock(clock), .rstn(rstn), .drive_open(m_op), .drive_close(m_cl), .pos_mm(pos),
        .closed_end(clo), .open_end(ope), .meas_mass(ms), .meas_friction(fr),
        .meas_energy(en), .meas_speed(sp));
    // record where each opening stroke of the learn run turned
    always @(posedge clock)
    begin
        if (act && po && !m_op)
            peaks.push_back(pos);
        po <= m_op;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic pulse(ref logic k);
        k = 1'b1;
        step(1);
        k = 1'b0;
        step(1);
    endtask
    function logic pk_ok(input int i, input logic [POS_W-1:0] e);
        return peaks.size() > i && peaks[i] >= e && peaks[i] <= e + 16'h0003;
    endfunction
    function logic [1:0] mexp(input logic [5:0] v);
        logic o;
        logic c;
        o = (v[5] & !v[1]) | (v[3] & !v[0]);
        c = (v[4] & !v[1]) | (v[2] & !v[0]);
        return {o, c & !o};
    endfunction
    task complete_run;
        if (error_cnt == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task t_abort;
        lb = 1'b1;
        step(2);
        lb = 1'b0;
        step(10);
        check(act, 1'b0);
        nm = 1'b0;
        lb = 1'b1;
        step(8);
        lb = 1'b0;
        nm = 1'b1;
        step(2);
        check(act, 1'b0);
    endtask
    task t_learn;
        int n;
        lb = 1'b1;
        step(8);
        lb = 1'b0;
        n = 0;
        while (!st && n < 5000)
        begin
            step(1);
            n++;
        end
        check(st, 1'b1);
        check(peaks.size(), 4);
        check(pk_ok(0, PRE_OPEN_MM) && pk_ok(1, PRE_OPEN_MM), 1'b1);
        check(pk_ok(2, FRICT_MM), 1'b1);
        check(pk_ok(3, 16'h0258), 1'b1);
        check(wid, 16'h0258);
        check({mq, fq}, {MASS, FRIC});
        check({eq, sq}, {ENRG, SPD});
    endtask
    task t_keypad;
        int n;
        pulse(ku);
        pulse(ku);
        check(sel, 6'h02);
        pulse(ke);
        check(fl, 1'b1);
        pulse(ku);
        pulse(ku);
        pulse(kd);
        check(pev, 16'h0011);
        ke = 1'b1;
        step(1);
        ke = 1'b0;
        n = 0;
        while (!pwr && n < 5)
        begin
            step(1);
            n++;
        end
        check({pwr, wsel, wv}, {1'b1, 6'h02, 16'h0011});
        step(1);
        check(pwr, 1'b0);
        // outside normal mode the commit must wait
        nm = 1'b0;
        pulse(ke);
        pulse(ke);
        n = 0;
        repeat (4)
        begin
            step(1);
            n += int'(pwr);
        end
        check(n, 0);
        ima = 1'b1;
        step(1);
        check({pwr, wsel, wv}, {1'b1, 6'h02, 16'h0010});
        nm = 1'b1;
        ima = 1'b0;
        step(1);
        check(pwr, 1'b0);
        ce = 1'b0;
        pulse(ku);
        ce = 1'b1;
        step(1);
        check(sel, 6'h02);
    endtask
    task t_manual;
        mo = 1'b1;
        step(300);
        mo = 1'b0;
        step(2);
        for (int i = 0; i < 64; i++)
        begin
            {mo, mc, eo, ec, stp, lck} = i[5:0];
            step(2);
            check({m_op, m_cl}, mexp(i[5:0]));
            check(spd, (mexp(i[5:0]) != 2'b00) ? SPD_SLOW : SPD_STOP);
            {mo, mc, eo, ec, stp, lck} = 6'h00;
            step(2);
            check({m_op, m_cl}, 2'b00);
            check(spd, SPD_STOP);
        end
    endtask
    initial
    begin
        #100_000;
        error_cnt++;
        complete_run;
    end
    initial
    begin
        repeat (4) @(posedge clock);
        #1 rstn = 1'b1;
        step(1);
        t_abort;
        t_learn;
        t_keypad;
        t_manual;
        complete_run;
    end
endmodule
`default_nettype wire
